/* inc/ssprg_pkg.sv */
package ssprg_pkg;
    // Byte addresses of the register words
    localparam logic [4:0] ADDR_RELOAD = 5'h00;
    localparam logic [4:0] ADDR_BUFFER = 5'h04;
    localparam logic [4:0] ADDR_CTL_ONE = 5'h08;
    localparam logic [4:0] ADDR_CTL_TWO = 5'h0C;
    localparam logic [4:0] ADDR_CTL_THREE = 5'h10;
    localparam logic [4:0] ADDR_MASK = 5'h14;
    localparam logic [4:0] ADDR_STATUS = 5'h18;
    localparam logic [4:0] ADDR_FLAGS = 5'h1C;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [23:0] PAD_ZERO = 24'h000000;

    // Clock and instruction cycle (oscillator / 4)
    localparam int CORE_CLK_HZ = 50_000_000;
    localparam int TICK_DIV = 4;
    localparam int INSTR_HZ = CORE_CLK_HZ / TICK_DIV;
    localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
    localparam logic [1:0] TICK_ZERO = 2'h0;
    localparam logic [1:0] TICK_STEP = 2'h1;

    // Status field positions
    localparam int ST_PHASE = 7;
    localparam int ST_CKE = 6;
    localparam int ST_DA = 5;
    localparam int ST_STOP = 4;
    localparam int ST_START = 3;
    localparam int ST_RW = 2;
    localparam int ST_ADDR_UPD = 1;
    localparam int ST_FULL = 0;

    // Control one and two field positions
    localparam int C1_PORT_EN = 5;
    localparam int C1_MODE_HI = 3;
    localparam int C2_ACK_GO = 4;
    localparam int C2_RECV_GO = 3;
    localparam int C2_STOP_GO = 2;
    localparam int C2_RESTART_GO = 1;
    localparam int C2_START_GO = 0;
    localparam logic [7:0] C2_GO_MASK = 8'h1F;

    // Event flag word fields
    localparam int FL_EVENT = 0;
    localparam int FL_COLL = 1;

    // Mode select codes
    localparam logic [3:0] MODE_SPI_SLAVE_SS = 4'h4;
    localparam logic [3:0] MODE_SPI_SLAVE = 4'h5;
    localparam logic [3:0] MODE_I2C_SL7 = 4'h6;
    localparam logic [3:0] MODE_I2C_SL10 = 4'h7;
    localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
    localparam logic [3:0] MODE_SPI_MASTER_RATE = 4'hA;
    localparam logic [3:0] MODE_I2C_FW = 4'hB;
    localparam logic [3:0] MODE_I2C_SL7_SP = 4'hE;
    localparam logic [3:0] MODE_I2C_SL10_SP = 4'hF;
    localparam logic [3:0] MODE_SPI_LAST_MASTER = 4'h3;

    typedef enum logic [2:0] {
        STOP_IDLE,
        STOP_SDA_LOW,
        STOP_SCL_REL,
        STOP_HOLD,
        STOP_SDA_REL,
        STOP_TAIL
    } ssprg_stop_t;

    function automatic logic ssprg_is_i2c(input logic [3:0] m);
        ssprg_is_i2c = (m == MODE_I2C_SL7) || (m == MODE_I2C_SL10) || (m == MODE_I2C_MASTER) ||
            (m == MODE_I2C_FW) || (m == MODE_I2C_SL7_SP) || (m == MODE_I2C_SL10_SP);
    endfunction

    function automatic logic ssprg_is_spi_master(input logic [3:0] m);
        ssprg_is_spi_master = (m <= MODE_SPI_LAST_MASTER) || (m == MODE_SPI_MASTER_RATE);
    endfunction

    function automatic logic ssprg_is_spi(input logic [3:0] m);
        ssprg_is_spi = ssprg_is_spi_master(m) || (m == MODE_SPI_SLAVE_SS) || (m == MODE_SPI_SLAVE);
    endfunction

    function automatic logic ssprg_is_i2c_slave(input logic [3:0] m);
        ssprg_is_i2c_slave = ssprg_is_i2c(m) && (m != MODE_I2C_MASTER) && (m != MODE_I2C_FW);
    endfunction
endpackage

/* rtl/ssprg_top.sv */
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
// Contract
// [R1] Stop: after SDA released and counter expires, SDA low means collision.
// [R2] Stop: SCL low after its release, before SDA rises, means collision.
// [R3] Stop drives SDA low, releases SCL, waits SCL high, counts, then samples.
// [R4] Counter reloads from reload register; buffer write in master mode starts it.
// [R5] Counter stops when operation completes; clock output holds its level.
// [R6] Counter reloads twice per serial clock period.
// [R7] Serial clock equals oscillator over four times (reload plus one); the code gives oscillator over eight times (reload plus one).
// [R8] Software never uses reload values 0, 1 or 2 for I2C.
// [R9] Bit 7 in SPI master picks end or mid sampling; slave keeps it clear.
// [R10] Bit 7 in I2C disables slew control when set.
// [R11] Bit 6 in SPI launches data on active-to-idle edge when set.
// [R12] Bit 6 in I2C selects SMBus input thresholds when set.
// [R13] Bit 5 shows data (1) or address (0) for last byte.
// [R14] Bit 4 shows Stop seen last; cleared by reset or disable.
// [R15] Bit 3 shows Start seen last; cleared by reset or disable.
// [R16] Bit 2 in slave mode holds last matched address direction.
// [R17] Bit 2 in master mode shows transmit in progress; idle output combines it.
// [R18] Bit 1 shows the address needs updating in 10-bit mode.
// [R19] Bit 0 on receive is set when a byte completes, clear when empty.
// [R20] Bit 0 on I2C transmit is set during transmit, clear when done.
// [R21] Any collision sets the collision flag and idles the port.
// [R22] Collision releases both lines and clears sequence enable bits.
// [R23] One counter period after Stop, clear Stop enable and set event flag.
// [R24] Counter decrements once per instruction cycle and expires at zero.
// [R25] Only status bits 7 and 6 take software writes.
module ssprg_top
    import ssprg_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic rx_done_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic tx_done_i,
    input wire logic data_byte_i,
    input wire logic rw_dir_i,
    input wire logic addr_update_i,
    input wire logic start_det_i,
    input wire logic stop_det_i,
    input wire logic bus_collision_i,
    input wire logic [4:0] seq_clear_i,
    output logic [7:0] tx_byte_o,
    output logic tx_load_o,
    output logic rate_expire_o,
    output logic rate_clk_o,
    output logic port_enable_o,
    output logic [3:0] mode_o,
    output logic [4:0] seq_go_o,
    output logic [7:0] control_three_o,
    output logic [7:0] address_mask_o,
    output logic port_idle_o,
    output logic sample_at_end_o,
    output logic launch_on_idle_o,
    output logic slew_ctrl_off_o,
    output logic smbus_levels_o,
    output logic collision_flag_o,
    output logic serial_event_flag_o
);
    logic done_reg;
    logic [31:0] rdata_reg;
    logic [7:0] reload_reg;
    logic [7:0] buf_reg;
    logic [7:0] ctl1_reg;
    logic [7:0] ctl2_reg;
    logic [7:0] ctl3_reg;
    logic [7:0] mask_reg;
    logic phase_reg;
    logic cke_reg;
    logic start_seen_reg;
    logic stop_seen_reg;
    logic full_reg;
    logic xfer_busy_reg;
    logic event_flag_reg;
    logic coll_flag_reg;
    logic [1:0] tick_cnt_reg;
    logic [7:0] rate_cnt_reg;
    logic rate_clk_reg;
    logic scl_oe_reg;
    logic sda_oe_reg;
    ssprg_stop_t state_reg;
    ssprg_stop_t state_next;

    // Bus decode: one wait state on every access
    wire bus_req = avs_read_i | avs_write_i;
    wire acc_wr = avs_write_i & done_reg & avs_byteenable_i[0];
    wire acc_rd = avs_read_i & done_reg;
    wire wr_reload = acc_wr && (avs_address_i == ADDR_RELOAD);
    wire wr_buf = acc_wr && (avs_address_i == ADDR_BUFFER);
    wire wr_ctl1 = acc_wr && (avs_address_i == ADDR_CTL_ONE);
    wire wr_ctl2 = acc_wr && (avs_address_i == ADDR_CTL_TWO);
    wire wr_ctl3 = acc_wr && (avs_address_i == ADDR_CTL_THREE);
    wire wr_mask = acc_wr && (avs_address_i == ADDR_MASK);
    wire wr_stat = acc_wr && (avs_address_i == ADDR_STATUS);
    wire wr_flags = acc_wr && (avs_address_i == ADDR_FLAGS);
    wire rd_buf = acc_rd && (avs_address_i == ADDR_BUFFER);
    wire [7:0] wbyte = avs_writedata_i[7:0];

    // Mode decode
    wire [3:0] mode = ctl1_reg[C1_MODE_HI:0];
    wire port_en = ctl1_reg[C1_PORT_EN];
    wire is_i2c = ssprg_is_i2c(mode);
    wire is_spi = ssprg_is_spi(mode);
    wire is_i2c_master = (mode == MODE_I2C_MASTER);
    wire rate_master = is_i2c_master || (mode == MODE_SPI_MASTER_RATE);

    // Instruction cycle enable and rate counter
    wire tick = (tick_cnt_reg == TICK_LAST); // [R24]
    wire stop_counting = (state_reg == STOP_HOLD) || (state_reg == STOP_SDA_REL) ||
        (state_reg == STOP_TAIL);
    wire free_run = xfer_busy_reg & rate_master & port_en;
    wire rate_run = stop_counting | free_run; // [R5]
    wire rate_zero = (rate_cnt_reg == BYTE_ZERO);
    wire rate_expire = tick & rate_run & rate_zero; // [R24]
    wire xfer_start = wr_buf & rate_master & port_en; // [R4]
    wire stop_load = ((state_reg == STOP_SCL_REL) && scl_i) ||
        (rate_expire && ((state_reg == STOP_HOLD) || ((state_reg == STOP_SDA_REL) && sda_i)));
    wire rate_load = xfer_start | stop_load | (rate_expire & free_run & ~stop_counting); // [R6]

    // Stop sequence collision and completion
    wire coll_hold = (state_reg == STOP_HOLD) && !scl_i; // [R2]
    wire coll_rel = (state_reg == STOP_SDA_REL) && !sda_i && // [R1] [R2]
        (!scl_i || rate_expire);
    wire stop_coll = coll_hold | coll_rel;
    wire any_coll = stop_coll | (bus_collision_i & port_en); // [R21]
    wire stop_ok = (state_reg == STOP_SDA_REL) && rate_expire && sda_i;
    wire stop_done = (state_reg == STOP_TAIL) && rate_expire; // [R23]
    wire stop_begin = (state_reg == STOP_IDLE) && ctl2_reg[C2_STOP_GO] && is_i2c_master && port_en;

    // Status byte
    wire rw_bit = is_i2c_master ? xfer_busy_reg : // [R16] [R17]
        (ssprg_is_i2c_slave(mode) & rw_dir_i);
    wire [7:0] status_byte = {phase_reg, cke_reg, data_byte_i & is_i2c, stop_seen_reg, // [R13]
        start_seen_reg, rw_bit, addr_update_i & is_i2c, full_reg}; // [R18]
    wire [7:0] flags_byte = {6'h00, coll_flag_reg, event_flag_reg};

    wire [7:0] rd_mux = (avs_address_i == ADDR_RELOAD) ? reload_reg :
        (avs_address_i == ADDR_BUFFER) ? buf_reg :
        (avs_address_i == ADDR_CTL_ONE) ? ctl1_reg :
        (avs_address_i == ADDR_CTL_TWO) ? ctl2_reg :
        (avs_address_i == ADDR_CTL_THREE) ? ctl3_reg :
        (avs_address_i == ADDR_MASK) ? mask_reg :
        (avs_address_i == ADDR_STATUS) ? status_byte :
        (avs_address_i == ADDR_FLAGS) ? flags_byte : BYTE_ZERO;

    // Next values of the sticky and shared state
    wire [7:0] ctl2_hw = ctl2_reg & ~({3'h0, seq_clear_i} |
        (any_coll ? C2_GO_MASK : BYTE_ZERO) | // [R22]
        (stop_done ? (BYTE_ONE << C2_STOP_GO) : BYTE_ZERO)); // [R23]
    // Software may re-arm a bit in the cycle hardware drops it
    wire [7:0] ctl2_next = wr_ctl2 ? wbyte : ctl2_hw;
    // Set beats clear for every hardware-set flag except start seen, which a Stop clears; disable clears both seen bits
    wire full_next = (wr_buf & port_en) | rx_done_i | // [R19] [R20]
        (full_reg & ~(tx_done_i | rd_buf | any_coll | ~port_en));
    wire busy_next = xfer_start | (xfer_busy_reg & ~(tx_done_i | any_coll | ~port_en)); // [R5]
    wire event_next = stop_done | (event_flag_reg & ~(wr_flags & wbyte[FL_EVENT])); // [R23]
    wire coll_next = any_coll | (coll_flag_reg & ~(wr_flags & wbyte[FL_COLL])); // [R21]
    wire stop_set = stop_det_i | stop_ok;
    wire stop_seen_next = port_en & (stop_set | (stop_seen_reg & ~start_det_i)); // [R14]
    wire start_seen_next = port_en & ~stop_set & (start_det_i | start_seen_reg); // [R15]

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            STOP_IDLE: begin
                if (stop_begin) begin
                    state_next = STOP_SDA_LOW;
                end
            end
            STOP_SDA_LOW: begin
                if (!sda_i && !sda_oe_reg) begin
                    state_next = STOP_SDA_LOW;
                end else if (!sda_i) begin
                    state_next = STOP_SCL_REL; // [R3]
                end
            end
            STOP_SCL_REL: begin
                if (scl_i) begin
                    state_next = STOP_HOLD; // [R3]
                end
            end
            STOP_HOLD: begin
                if (rate_expire) begin
                    state_next = STOP_SDA_REL;
                end
            end
            STOP_SDA_REL: begin
                if (stop_ok) begin
                    state_next = STOP_TAIL;
                end
            end
            STOP_TAIL: begin
                if (rate_expire) begin
                    state_next = STOP_IDLE;
                end
            end
            default: begin
                state_next = STOP_IDLE;
            end
        endcase
        if (any_coll || !port_en) begin
            state_next = STOP_IDLE; // [R21] [R22]
        end
    end

    wire sda_drive_next = (state_next == STOP_SDA_LOW) || (state_next == STOP_SCL_REL) ||
        (state_next == STOP_HOLD);
    wire scl_drive_next = (state_next == STOP_SDA_LOW);

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            done_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            done_reg <= bus_req & ~done_reg;
            if (bus_req && !done_reg) begin
                rdata_reg <= {PAD_ZERO, rd_mux};
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            reload_reg <= RESET_BYTE;
            ctl1_reg <= RESET_BYTE;
            ctl3_reg <= RESET_BYTE;
            mask_reg <= RESET_BYTE;
            phase_reg <= 1'b0;
            cke_reg <= 1'b0;
        end else begin
            if (wr_reload) reload_reg <= wbyte;
            if (wr_ctl1) ctl1_reg <= wbyte;
            if (wr_ctl3) ctl3_reg <= wbyte;
            if (wr_mask) mask_reg <= wbyte;
            if (wr_stat) begin
                phase_reg <= wbyte[ST_PHASE]; // [R25]
                cke_reg <= wbyte[ST_CKE]; // [R25]
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            buf_reg <= RESET_BYTE;
            ctl2_reg <= RESET_BYTE;
            full_reg <= 1'b0;
            xfer_busy_reg <= 1'b0;
            event_flag_reg <= 1'b0;
            coll_flag_reg <= 1'b0;
            stop_seen_reg <= 1'b0;
            start_seen_reg <= 1'b0;
        end else begin
            if (rx_done_i) begin
                buf_reg <= rx_byte_i;
            end else if (wr_buf) begin
                buf_reg <= wbyte;
            end
            ctl2_reg <= ctl2_next;
            full_reg <= full_next;
            xfer_busy_reg <= busy_next;
            event_flag_reg <= event_next;
            coll_flag_reg <= coll_next;
            stop_seen_reg <= stop_seen_next;
            start_seen_reg <= start_seen_next;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tick_cnt_reg <= TICK_ZERO;
            rate_cnt_reg <= RESET_BYTE;
            rate_clk_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick ? TICK_ZERO : tick_cnt_reg + TICK_STEP;
            if (rate_load) begin
                rate_cnt_reg <= reload_reg; // [R4] [R6]
            end else if (tick && rate_run && !rate_zero) begin
                rate_cnt_reg <= rate_cnt_reg - BYTE_ONE; // [R24]
            end
            if (rate_expire && free_run && !stop_counting) begin
                rate_clk_reg <= ~rate_clk_reg; // [R7]
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= STOP_IDLE;
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sda_oe_reg <= sda_drive_next; // [R3] [R22]
            scl_oe_reg <= scl_drive_next; // [R3] [R22]
        end
    end

    assign avs_waitrequest_o = bus_req & ~done_reg;
    assign avs_readdata_o = rdata_reg;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_oe_reg;
    assign sda_oe_o = sda_oe_reg;
    assign tx_byte_o = buf_reg;
    assign tx_load_o = wr_buf & port_en;
    assign rate_expire_o = rate_expire;
    assign rate_clk_o = rate_clk_reg;
    assign port_enable_o = port_en;
    assign mode_o = mode;
    assign seq_go_o = ctl2_reg[C2_ACK_GO:C2_START_GO];
    assign control_three_o = ctl3_reg;
    assign address_mask_o = mask_reg;
    assign port_idle_o = ~(xfer_busy_reg | (|ctl2_reg[C2_ACK_GO:C2_START_GO])); // [R17]
    assign sample_at_end_o = phase_reg & ssprg_is_spi_master(mode); // [R9]
    assign launch_on_idle_o = cke_reg & is_spi; // [R11]
    assign slew_ctrl_off_o = phase_reg & is_i2c; // [R10]
    assign smbus_levels_o = cke_reg & is_i2c; // [R12]
    assign collision_flag_o = coll_flag_reg;
    assign serial_event_flag_o = event_flag_reg;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_tick_spacing: assert property (tick |=> !tick [*3] ##1 tick) // [R24]
        else $error("instruction tick spacing wrong");
    chk_sda_low_coll: assert property ((state_reg == STOP_SDA_REL && rate_expire && !sda_i)
        |=> coll_flag_reg && state_reg == STOP_IDLE && !sda_oe_o && !scl_oe_o) // [R1]
        else $error("stop sda sample collision missed");
    // A software write to control two in that cycle wins over the clear
    chk_scl_low_coll: assert property ((state_reg == STOP_HOLD && !scl_i && !wr_ctl2)
        |=> coll_flag_reg && !ctl2_reg[C2_STOP_GO]) // [R2]
        else $error("stop scl collision missed");
    chk_scl_release: assert property ((state_reg == STOP_SDA_LOW && !sda_i && sda_oe_reg
        && !any_coll && port_en) |=> !scl_oe_o ##0 sda_oe_o) // [R3]
        else $error("scl not released after sda low");
    chk_buf_start: assert property ((xfer_start && !stop_counting)
        |=> rate_cnt_reg == $past(reload_reg) && xfer_busy_reg) // [R4]
        else $error("buffer write did not start counter");
    chk_clk_hold: assert property (!free_run |=> $stable(rate_clk_o)) // [R5]
        else $error("rate clock moved while stopped");
    chk_reload_expire: assert property ((rate_expire && free_run && !xfer_start && !stop_counting)
        |=> rate_cnt_reg == $past(reload_reg) && rate_clk_o != $past(rate_clk_o)) // [R6]
        else $error("counter not reloaded at expiry");
    chk_stop_finish: assert property ((state_reg == STOP_TAIL && rate_expire && !any_coll
        && !wr_ctl2 && !wr_flags) |=> event_flag_reg && !ctl2_reg[C2_STOP_GO]) // [R23]
        else $error("stop completion not flagged");
    chk_disable_clr: assert property (!port_en |=> !stop_seen_reg && !start_seen_reg) // [R14]
        else $error("start stop bits survive disable");
    chk_status_ro: assert property ((wr_stat && !rx_done_i && !tx_done_i && !any_coll && port_en)
        |=> full_reg == $past(full_reg) && phase_reg == $past(wbyte[ST_PHASE])) // [R25]
        else $error("status write reached read only bits");
    chk_coll_flag: assert property (bus_collision_i && port_en |=> coll_flag_reg
        && seq_go_o == ($past(wr_ctl2) ? $past(wbyte[C2_ACK_GO:C2_START_GO]) : 5'h00)) // [R22]
        else $error("external collision not handled");

    cov_stop_ok: cover property (stop_done);
    cov_stop_coll: cover property (stop_coll);
    cov_free_toggle: cover property (rate_expire && free_run ##[1:40] rate_expire);
    cov_rx_read: cover property (rx_done_i ##[1:10] rd_buf);
endmodule

/* tb/ssprg_bus_peer.sv */
`timescale 1ns/10ps
module ssprg_bus_peer (
    input wire logic scl_oe_i,
    input wire logic sda_oe_i,
    input wire logic scl_hold_i,
    input wire logic sda_hold_i,
    output logic scl_o,
    output logic sda_o
);
    // Pull-ups: a released line reads high, never its last value
    // Holds stand for a stretching slave or a second master
    assign scl_o = ~(scl_oe_i | scl_hold_i);
    assign sda_o = ~(sda_oe_i | sda_hold_i);
endmodule

/* tb/ssprg_tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module ssprg_tb_top;
    import ssprg_pkg::*;
    logic clk, rst_n, rd, wr, wtr, scl, sda, scl_oe, sda_oe, rxd, txd, dby, rwd, aup;
    logic sdt, pdt, bco, rexp, rclk, idle, sae, cke, slew, smb, coll, evt, sclh, sdah;
    logic [4:0] adr, sgo;
    logic [31:0] wd, rdd;
    logic [7:0] rxb, txb;
    int err_count, checks;
    ssprg_top i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdd), .avs_waitrequest_o(wtr), .scl_i(scl), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .rx_done_i(rxd),
        .rx_byte_i(rxb), .tx_done_i(txd), .data_byte_i(dby), .rw_dir_i(rwd),
        .addr_update_i(aup), .start_det_i(sdt), .stop_det_i(pdt), .bus_collision_i(bco),
        .seq_clear_i(5'h00), .tx_byte_o(txb), .tx_load_o(), .rate_expire_o(rexp),
        .rate_clk_o(rclk), .port_enable_o(), .mode_o(), .seq_go_o(sgo),
        .control_three_o(), .address_mask_o(), .port_idle_o(idle), .sample_at_end_o(sae),
        .launch_on_idle_o(cke), .slew_ctrl_off_o(slew), .smbus_levels_o(smb),
        .collision_flag_o(coll), .serial_event_flag_o(evt));
    ssprg_bus_peer i_peer (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_hold_i(sclh),
        .sda_hold_i(sdah), .scl_o(scl), .sda_o(sda));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task close_out;
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Holds the request until waitrequest is sampled low
    task bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk);
        adr <= a;
        wd <= {PAD_ZERO, d};
        wr <= w;
        rd <= ~w;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wtr === 1'b0) break;
        end
        q = rdd[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
        if (n == 20) begin
            err_count++;
            close_out();
        end
    endtask
    task wt(input int k, input logic v, output int n);
        logic s;
        for (n = 1; n <= 400; n++) begin
            @(posedge clk);
            case (k)
                0: s = scl_oe;
                1: s = sda_oe;
                2: s = sgo[C2_STOP_GO];
                3: s = rexp;
                default: s = coll;
            endcase
            if (s === v) break;
        end
        if (n > 400) begin
            err_count++;
            close_out();
        end
    endtask
    task t_status;
        logic [7:0] q;
        bus(0, ADDR_STATUS, 8'h00, q);
        `CHK(q, RESET_BYTE)
        bus(0, 5'h02, 8'h00, q);
        `CHK(q, BYTE_ZERO)
        bus(1, ADDR_CTL_ONE, 8'h26, q);
        {dby, rwd, aup, sdt} <= 4'hF;
        @(posedge clk);
        sdt <= 1'b0;
        bus(0, ADDR_STATUS, 8'h00, q);
        `CHK(q, 8'h2E)
        rxb <= 8'hA5;
        rxd <= 1'b1;
        @(posedge clk);
        rxd <= 1'b0;
        bus(0, ADDR_STATUS, 8'h00, q);
        `CHK(q, 8'h2F)
        bus(0, ADDR_BUFFER, 8'h00, q);
        `CHK(q, 8'hA5)
        pdt <= 1'b1;
        @(posedge clk);
        pdt <= 1'b0;
        bus(1, ADDR_STATUS, 8'hFF, q);
        bus(0, ADDR_STATUS, 8'h00, q);
        `CHK(q, 8'hF6)
        `CHK({slew, smb}, 2'b11)
        bus(1, ADDR_CTL_ONE, 8'h06, q);
        bus(0, ADDR_STATUS, 8'h00, q);
        `CHK(q, 8'hE6)
        bus(1, ADDR_CTL_ONE, 8'h20, q);
        @(posedge clk);
        `CHK({sae, cke}, 2'b11)
        bco <= 1'b1;
        @(posedge clk);
        bco <= 1'b0;
        bus(0, ADDR_FLAGS, 8'h00, q);
        `CHK(q, 8'h02)
        bus(1, ADDR_FLAGS, 8'h03, q);
    endtask
    task t_rate;
        int a, b, e;
        logic rc;
        logic [7:0] q;
        bus(1, ADDR_RELOAD, 8'h03, q);
        bus(1, ADDR_CTL_ONE, 8'h2A, q);
        bus(1, ADDR_BUFFER, 8'h5A, q);
        bus(0, ADDR_STATUS, 8'h00, q);
        `CHK(q[ST_FULL], 1'b1)
        wt(3, 1'b1, a);
        `CHK(txb, 8'h5A)
        `CHK(a <= 20, 1'b1)
        rc = rclk;
        wt(3, 1'b0, a);
        `CHK(rclk, ~rc)
        wt(3, 1'b1, b);
        `CHK(a + b, 16)
        txd <= 1'b1;
        @(posedge clk);
        txd <= 1'b0;
        repeat (2) @(posedge clk);
        rc = rclk;
        e = 0;
        repeat (60) begin
            @(posedge clk);
            e += int'(rexp === 1'b1);
        end
        `CHK(e, 0)
        `CHK(rclk, rc)
        bus(0, ADDR_STATUS, 8'h00, q);
        `CHK(q[ST_FULL], 1'b0)
    endtask
    task t_stop_ok;
        int n;
        logic [7:0] q;
        bus(1, ADDR_CTL_ONE, 8'h28, q);
        sclh <= 1'b1;
        bus(1, ADDR_CTL_TWO, 8'h04, q);
        wt(1, 1'b1, n);
        `CHK(idle, 1'b0)
        wt(0, 1'b0, n);
        repeat (10) @(posedge clk);
        // Stretched clock must hold off the count
        `CHK(sda_oe, 1'b1)
        sclh <= 1'b0;
        wt(1, 1'b0, n);
        `CHK(n >= 15 && n <= 22, 1'b1)
        wt(2, 1'b0, n);
        `CHK(n >= 28 && n <= 40, 1'b1)
        bus(0, ADDR_STATUS, 8'h00, q);
        `CHK(q[ST_STOP], 1'b1)
        bus(0, ADDR_FLAGS, 8'h00, q);
        `CHK(q, 8'h01)
        bus(1, ADDR_FLAGS, 8'h03, q);
    endtask
    task t_stop_coll(input logic on_sda);
        int n;
        logic [7:0] q;
        bus(1, ADDR_CTL_TWO, 8'h04, q);
        // Idle SCL drive is already low, so wait for the sequence to take it first
        wt(0, 1'b1, n);
        wt(0, 1'b0, n);
        if (on_sda) begin
            wt(1, 1'b0, n);
            sdah <= 1'b1;
        end else begin
            repeat (4) @(posedge clk);
            sclh <= 1'b1;
        end
        wt(4, 1'b1, n);
        `CHK(n <= 24, 1'b1)
        @(posedge clk);
        `CHK({sgo, sda_oe, scl_oe}, 7'h00)
        {sdah, sclh} <= 2'b00;
        bus(0, ADDR_FLAGS, 8'h00, q);
        `CHK(q, 8'h02)
        bus(1, ADDR_FLAGS, 8'h03, q);
    endtask
    initial begin
        {rst_n, rd, wr, rxd, txd, dby, rwd, aup, sdt, pdt, bco, sclh, sdah} = 13'h0000;
        adr = 5'h00;
        wd = 32'h00000000;
        rxb = 8'h00;
        err_count = 0;
        checks = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_status();
        t_rate();
        t_stop_ok();
        t_stop_coll(1'b1);
        t_stop_coll(1'b0);
        close_out();
    end
endmodule
